// ### hw_reset_cfg.svh
`ifndef HW_RESET_CFG_SVH
`define HW_RESET_CFG_SVH
// clock rate and documented times
`define CLK_HZ            20000000
`define REJECT_NS         5000
`define ACCEPT_NS         9000
`define CANCEL_SLEEP_US   5000
`define CANCEL_AWAKE_US   120000
// glitch filter: accept once low for this many cycles (between reject and accept bounds)
`define FILT_CYC          ((`ACCEPT_NS * (`CLK_HZ / 1000000)) / 1000)
`define REJECT_CYC        ((`REJECT_NS * (`CLK_HZ / 1000000) + 999) / 1000)
// longest times round down
`define CANCEL_SLEEP_CYC  ((`CANCEL_SLEEP_US / 1000) * (`CLK_HZ / 1000))
`define CANCEL_AWAKE_CYC  ((`CANCEL_AWAKE_US / 1000) * (`CLK_HZ / 1000))
`define BLANK_CYC_DEF     `CANCEL_AWAKE_CYC
`define CNT_W             24
`define ID_W              24
`define COMMON_VOLTAGE_SETTING_W            8
`define CFG_W             16
`endif

// ### hw_reset_pkg.sv
package hw_reset_pkg;
  `include "hw_reset_cfg.svh"
  typedef enum logic [1:0] {
    ST_RUN    = 2'b00,
    ST_RESET  = 2'b01,
    ST_RELOAD = 2'b11,
    ST_SETTLE = 2'b10
  } seq_state_type;
  typedef struct packed {
    logic [`ID_W-1:0]   id_bytes;
    logic [`COMMON_VOLTAGE_SETTING_W-1:0] common_voltage_setting;
    logic [`CFG_W-1:0]  settings;
  } nv_image_type;
endpackage

// ### display_hw_reset_sequencer.sv
`timescale 1ns/1ps
`include "hw_reset_cfg.svh"
module display_hw_reset_sequencer
  import hw_reset_pkg::*;
#(
  parameter int CANCEL_SLEEP_CYC = `CANCEL_SLEEP_CYC,
  parameter int CANCEL_AWAKE_CYC = `CANCEL_AWAKE_CYC,
  parameter int FILT_CYC         = `FILT_CYC
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_i,
  input  wire logic         hw_reset_line_n_i,  // pin, active low
  input  wire logic         sleep_out_i,        // current power mode, 1 = awake
  input  wire logic         cmd_valid_i,        // command from interface logic
  input  wire nv_image_type nv_data_i,          // nonvolatile_store contents
  output logic              cmd_accept_o,
  output logic              blank_o,
  output logic              in_reset_o,
  output logic              reload_done_o,
  output nv_image_type      regs_o
);
  // elaboration checks: the filter must sit between the reject and accept bounds,
  // and every count must fit the shared counter width, or the timers would wrap
  if (FILT_CYC < `REJECT_CYC || FILT_CYC > `FILT_CYC || FILT_CYC < 1) begin : g_bad_filt
    $error("filter length outside reject/accept window");
  end
  if (CANCEL_SLEEP_CYC < 2 || CANCEL_AWAKE_CYC < CANCEL_SLEEP_CYC) begin : g_bad_cancel
    $error("cancel counts inconsistent");
  end
  if (CANCEL_AWAKE_CYC >= (1 << `CNT_W) || FILT_CYC >= (1 << `CNT_W)) begin : g_bad_width
    $error("counts do not fit the timer width");
  end

  logic          sync1_r, sync2_r, filt_r, filt_nxt;
  logic [`CNT_W-1:0] flt_cnt_r, flt_cnt_nxt, tmr_r, tmr_nxt;
  seq_state_type state_r, state_nxt;
  logic          awake_at_start_r, awake_nxt;
  nv_image_type  regs_nxt;
  logic          blank_nxt, in_reset_nxt, done_nxt, accept_nxt;

  // two-flop synchroniser; only sync2_r feeds logic
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
    end else begin
      sync1_r <= hw_reset_line_n_i;
      sync2_r <= sync1_r;
    end
  end

  // symmetric filter: level must hold FILT_CYC cycles to flip, so spikes are ignored
  // the same filter guards both edges, so a spike inside a low pulse only clears
  // the counter and never reaches the sequencer; the cost is a fixed release delay
  wire differs   = (sync2_r != filt_r);
  wire flt_full  = (flt_cnt_r == `CNT_W'(FILT_CYC - 1));
  assign filt_nxt    = (differs && flt_full) ? sync2_r : filt_r;
  assign flt_cnt_nxt = (differs && !flt_full) ? flt_cnt_r + `CNT_W'(1) : '0;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      filt_r    <= 1'b1;
      flt_cnt_r <= '0;
    end else begin
      filt_r    <= filt_nxt;
      flt_cnt_r <= flt_cnt_nxt;
    end
  end

  // edges of the filtered line; the release is counted from the filtered rise
  wire fall_det = filt_r && !filt_nxt;
  wire rise_det = !filt_r && filt_nxt;
  wire [`CNT_W-1:0] limit = awake_at_start_r ? `CNT_W'(CANCEL_AWAKE_CYC)
                                             : `CNT_W'(CANCEL_SLEEP_CYC);
  wire tmr_end  = (tmr_r >= limit - `CNT_W'(1));

  // sequencer; a new filtered fall always wins and restarts the reset
  // the power mode is taken only on a fall seen from run; a fall that restarts a
  // reset already under way keeps the mode of the first fall, since the panel
  // is blank by then and the longer awake wait must not be cut short
  always_comb begin
    state_nxt = state_r;
    tmr_nxt   = tmr_r;
    awake_nxt = awake_at_start_r;
    regs_nxt  = regs_o;
    unique case (state_r)
      ST_RUN: begin
        if (fall_det) begin
          state_nxt = ST_RESET;
          awake_nxt = sleep_out_i;
        end
      end
      ST_RESET: begin
        tmr_nxt = '0;
        if (rise_det) state_nxt = ST_RELOAD;
      end
      ST_RELOAD: begin
        regs_nxt  = nv_data_i;
        tmr_nxt   = tmr_r + `CNT_W'(1);
        state_nxt = ST_SETTLE;
      end
      ST_SETTLE: begin
        tmr_nxt = tmr_r + `CNT_W'(1);
        if (tmr_end) state_nxt = ST_RUN;
      end
    endcase
    if (fall_det && state_r != ST_RUN) begin
      state_nxt = ST_RESET;
    end
  end

  // outputs registered; blanking holds through the whole cancel interval
  // all flags are decoded from the next state so each output leaves a flip-flop
  // in the same cycle the state register changes
  assign blank_nxt    = (state_nxt != ST_RUN);
  assign in_reset_nxt = (state_nxt == ST_RESET);
  assign done_nxt     = (state_nxt == ST_SETTLE) || (state_nxt == ST_RUN && state_r == ST_SETTLE)
                        ? 1'b1 : (state_nxt == ST_RUN ? reload_done_o : 1'b0);
  assign accept_nxt   = cmd_valid_i && (state_nxt == ST_RUN);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_r          <= ST_RESET;
      tmr_r            <= '0;
      awake_at_start_r <= 1'b0;
      regs_o           <= '0;
      blank_o          <= 1'b1;
      in_reset_o       <= 1'b1;
      reload_done_o    <= 1'b0;
      cmd_accept_o     <= 1'b0;
    end else begin
      state_r          <= state_nxt;
      tmr_r            <= tmr_nxt;
      awake_at_start_r <= awake_nxt;
      regs_o           <= (state_nxt == ST_RESET) ? '0 : regs_nxt;
      blank_o          <= blank_nxt;
      in_reset_o       <= in_reset_nxt;
      reload_done_o    <= done_nxt;
      cmd_accept_o     <= accept_nxt;
    end
  end

  // checks on the filter
  reject_short_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (filt_r && !sync2_r && flt_cnt_r < `CNT_W'(FILT_CYC - 1)) |=> filt_r)
    else $error("short low pulse changed filtered line");
  filt_flip_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (filt_r != $past(filt_r)) |-> $past(flt_cnt_r) == `CNT_W'(FILT_CYC - 1))
    else $error("filtered line flipped before full count");
  spike_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_r == ST_RESET && sync2_r && flt_cnt_r == '0 && !filt_r) |=> state_r == ST_RESET)
    else $error("spike ended reset");
  // checks on the reload and the cancel interval
  reload_copy_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_r == ST_RELOAD && !fall_det) |=> regs_o == $past(nv_data_i))
    else $error("store image not loaded");
  regs_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_r == ST_RUN && $past(state_r) == ST_RUN) |-> $stable(regs_o))
    else $error("registers changed outside reload");
  release_reload_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_r == ST_RESET && rise_det) |=> state_r == ST_RELOAD)
    else $error("release did not start reload");
  done_settle_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state_r == ST_SETTLE |-> reload_done_o)
    else $error("reload done flag missing after reload");
  blank_reset_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state_r != ST_RUN |-> blank_o)
    else $error("display not blank during reset");
  in_reset_flag_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state_r == ST_RESET |-> in_reset_o)
    else $error("reset flag low while in reset");
  default_regs_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    state_r == ST_RESET |-> regs_o == '0)
    else $error("registers not at default in reset");
  blank_release_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_r == ST_SETTLE && tmr_end && !fall_det) |=> !blank_o)
    else $error("blanking held past cancel end");
  cancel_bound_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_r == ST_SETTLE) |-> tmr_r < limit)
    else $error("cancel interval overran");
  no_cmd_reload_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (state_r != ST_RUN) |-> !cmd_accept_o || $past(state_r) == ST_RUN)
    else $error("command accepted during reload");
  accept_run_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (cmd_valid_i && state_nxt == ST_RUN) |=> cmd_accept_o)
    else $error("command refused in run");
  // main scenarios: a reset, a spike inside it, an awake start, reload and finish
  reset_cv: cover property (@(posedge clk_sys_i) disable iff (rst_i) fall_det);
  spike_cv: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    state_r == ST_RESET && sync2_r && !filt_r);
  awake_cv: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    state_r == ST_RUN && fall_det && sleep_out_i);
  reload_cv: cover property (@(posedge clk_sys_i) disable iff (rst_i) state_r == ST_RELOAD);
  finish_cv: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    state_r == ST_SETTLE ##1 state_r == ST_RUN);
endmodule // display_hw_reset_sequencer

// ### host_model.sv
`timescale 1ns/1ps
// host side of the reset pin and the command strobe; all changes land on falling edges
module host_model (
  input  wire logic clk_sys_i,
  output logic      hw_reset_line_n_o,
  output logic      cmd_valid_o
);
  // pin idles high, no command until the bench asks for one
  initial begin
    hw_reset_line_n_o = 1'b1;
    cmd_valid_o = 1'b0;
  end
  // hold the pin at v for n cycles; low holds of 200 give the full 10us width
  task automatic drive(input logic v, input int n);
    @(negedge clk_sys_i) hw_reset_line_n_o = v;
    repeat (n) @(negedge clk_sys_i);
  endtask
  // commands are held through the wait window to probe their refusal there and their acceptance after it
  task automatic cmd(input logic v);
    cmd_valid_o = v;
  endtask
endmodule // host_model

// ### display_hw_reset_sequencer_test.sv
`timescale 1ns/1ps
module display_hw_reset_sequencer_test;
  import hw_reset_pkg::*;
  logic         clk_sys_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         sleep_out_i = 1'b0;
  nv_image_type nv_data_i = '0;
  wire logic    pin_n, cmd_v, cmd_accept_o, blank_o, in_reset_o, reload_done_o;
  nv_image_type regs_o;
  int           fails = 0;
  int           comparisons = 0;
  int           cyc = 0;
  host_model host (.clk_sys_i(clk_sys_i), .hw_reset_line_n_o(pin_n), .cmd_valid_o(cmd_v));
  // short cancel limits keep the run small; checks below are derived from 20 and 40
  display_hw_reset_sequencer #(.CANCEL_SLEEP_CYC(20), .CANCEL_AWAKE_CYC(40), .FILT_CYC(180))
    DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .hw_reset_line_n_i(pin_n),
    .sleep_out_i(sleep_out_i), .cmd_valid_i(cmd_v), .nv_data_i(nv_data_i),
    .cmd_accept_o(cmd_accept_o), .blank_o(blank_o), .in_reset_o(in_reset_o),
    .reload_done_o(reload_done_o), .regs_o(regs_o));
  initial forever #25 clk_sys_i = ~clk_sys_i;
  // hang guard, well above the roughly 1300 cycles the tests need
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // full reset with a spike inside it, commands held up the whole time
  task automatic do_reset(input logic awake, input nv_image_type img);
    sleep_out_i = awake;
    nv_data_i = img;
    host.cmd(1'b1);
    host.drive(1'b0, 200);
    check(in_reset_o, 1'b1);
    check(blank_o, 1'b1);
    host.drive(1'b1, 3);
    host.drive(1'b0, 50);
    check(in_reset_o, 1'b1);
    check(reload_done_o, 1'b0);
    host.drive(1'b1, 190);
    check(regs_o, img);
    check(cmd_accept_o, 1'b0);
    repeat (25) @(negedge clk_sys_i);
    check(blank_o, awake);
    repeat (20) @(negedge clk_sys_i);
    check(blank_o, 1'b0);
    check(cmd_accept_o, 1'b1);
    host.cmd(1'b0);
    $display("test reset awake=%0d done", awake);
  endtask
  // a 90-cycle low pulse sits under the 5us floor and must be ignored
  task automatic t_reject();
    host.drive(1'b0, 90);
    host.drive(1'b1, 200);
    check(in_reset_o, 1'b0);
    check(blank_o, 1'b0);
    check(reload_done_o, 1'b1);
    $display("test reject done");
  endtask
  initial begin
    repeat (10) @(negedge clk_sys_i);
    rst_i = 1'b0;
    do_reset(1'b0, 48'h5a_c3_91_3c_e2_07);
    t_reject();
    do_reset(1'b1, 48'ha5_3c_6e_c3_1d_f8);
    final_report();
  end
endmodule // display_hw_reset_sequencer_test
